//--- pkg/tpas_cfg.svh
`ifndef TPAS_CFG_SVH
`define TPAS_CFG_SVH

`define TPAS_CLK_HZ      10000000
`define TPAS_GAP_S       9
`define TPAS_PULSE_MAX_S 10
`define TPAS_DEB_US      1000
`define TPAS_VALID_AXLES 12'h004
`define TPAS_TEST_AXLES  12'h002
`define TPAS_REC_DEPTH   5'h10

`define TPAS_OFF_CTRL    8'h00
`define TPAS_OFF_TYPES   8'h04
`define TPAS_OFF_STATUS  8'h08
`define TPAS_OFF_EVENTS  8'h0c
`define TPAS_OFF_AXLES   8'h10
`define TPAS_OFF_REC     2'h1

`define TPAS_CTRL_MODE_LSB  0
`define TPAS_CTRL_SENS_LSB  2
`define TPAS_CTRL_RST       4'hc
`define TPAS_TYPES_RST      16'h0000
`define TPAS_IN_RST         7'h7c

`define TPAS_EV_ARRIVE   0
`define TPAS_EV_DEPART   1
`define TPAS_EV_ALARM    2
`define TPAS_EV_RECORD   3

`endif

//--- pkg/tpas_pkg.sv
`default_nettype none
package tpas_pkg;
    typedef enum logic [1:0] {TM_XDUCER, TM_APPROACH, TM_CONT} tpas_mode_t;
    typedef enum logic [1:0] {TC_NONE, TC_DROP, TC_TEST, TC_VALID}
        tpas_class_t;
    typedef enum logic [3:0] {
        AT_UNUSED, AT_DRAG, AT_HIGH, AT_WIDE, AT_SHIFT, AT_FENCE,
        AT_SLIP, AT_WATER, AT_COLLIDE, AT_FIRE, AT_POWER
    } tpas_alarm_t;
    typedef enum logic [1:0] {ST_IDLE, ST_PRESENT, ST_CONT} tpas_state_t;
endpackage
`default_nettype wire

//--- pkg/tpas_mem_if.sv
`timescale 1ns/1ns
`default_nettype none
interface tpas_mem_if;
    logic        wr_en;
    logic [3:0]  wr_addr;
    logic [15:0] wr_data;
    logic [3:0]  rd_addr;
    logic [15:0] rd_data;
    modport ctrl (output wr_en, output wr_addr, output wr_data,
                  output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data,
                  input rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- hdl/tpas_rec_mem.sv
`timescale 1ns/1ns
`default_nettype none
module tpas_rec_mem (
    input  wire logic clk,
    input  wire logic rst,
    tpas_mem_if.mem   mp
);
    logic [15:0] store [16];
    logic [15:0] rd_data_reg;

    // record array, no reset needed
    always_ff @(posedge clk)
    begin
        if (mp.wr_en)
        begin
            store[mp.wr_addr] <= mp.wr_data;
        end
    end

    // registered read port
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_reg <= 16'h0000;
        end
        else
        begin
            rd_data_reg <= store[mp.rd_addr];
        end
    end

    assign mp.rd_data = rd_data_reg;
endmodule
`default_nettype wire

//--- hdl/tpas_scanner.sv
`timescale 1ns/1ns
`default_nettype none
`include "tpas_cfg.svh"
module tpas_scanner #(
    parameter int unsigned GAP_CYC = `TPAS_GAP_S * `TPAS_CLK_HZ,
    parameter int unsigned DEB_CYC = `TPAS_DEB_US * (`TPAS_CLK_HZ / 1000000)
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        wheel_sensor_a,
    input  wire logic        wheel_sensor_b,
    input  wire logic        track_circuit_in,
    input  wire logic        alarm_contact_1,
    input  wire logic        alarm_contact_2,
    input  wire logic        alarm_contact_3,
    input  wire logic        alarm_contact_4,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             train_present,
    output logic             scan_active,
    output logic             event_pending
);
    // whole gap must pass before train end; kept below the pulse limit
    localparam int unsigned PULSE_MAX_CYC = `TPAS_PULSE_MAX_S * `TPAS_CLK_HZ;

    // accepts a type for the current activation scheme
    function automatic logic type_ok(input logic [3:0] t, input logic cont);
        type_ok = (t != tpas_pkg::AT_UNUSED)
                  && ((t <= tpas_pkg::AT_SHIFT)
                      || (cont && t <= tpas_pkg::AT_POWER));
    endfunction

    // byte-lane merge for register writes
    function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                               input logic [15:0] nw,
                                               input logic [1:0]  be);
        lane_merge = {be[1] ? nw[15:8] : old[15:8],
                      be[0] ? nw[7:0]  : old[7:0]};
    endfunction

    logic [6:0]        raw_in;
    logic [6:0]        sync1_reg;
    logic [6:0]        sync2_reg;
    logic [6:0]        deb_reg;
    logic [6:0]        deb_prev_reg;
    logic [15:0]       deb_cnt_reg [7];
    logic [3:0]        ctrl_reg;
    logic [15:0]       types_reg;
    logic [3:0]        events_reg;
    logic [3:0]        events_next;
    logic [3:0]        ev_set;
    logic [3:0]        ev_clr;
    logic [31:0]       gap_reg;
    logic [11:0]       axle_reg;
    logic [4:0]        rec_cnt_reg;
    logic [1:0]        class_reg;
    logic [1:0]        class_next;
    logic              rd_done_reg;
    logic              rec_sel_reg;
    logic [31:0]       rdata_reg;
    logic [31:0]       rd_word;
    tpas_pkg::tpas_state_t state_reg;
    tpas_pkg::tpas_state_t state_next;
    logic [1:0]        mode;
    logic [1:0]        sens_en;
    logic              is_xducer;
    logic              is_appr;
    logic              is_cont;
    logic [1:0]        wheel_rise;
    logic              start_pulse;
    logic              count_pulse;
    logic              track_open;
    logic [3:0]        alarm_act;
    logic [3:0]        alarm_rise;
    logic [3:0]        alarm_hit;
    logic              any_hit;
    logic [1:0]        hit_idx;
    logic              start_train;
    logic              end_train;
    logic              gap_over;
    logic              rec_write;
    logic              wr_ctrl;
    logic              wr_types;
    logic              wr_events;

    tpas_mem_if mem_bus ();

    tpas_rec_mem u_mem (
        .clk (clk),
        .rst (rst),
        .mp  (mem_bus.mem)
    );

    assign raw_in = {alarm_contact_4, alarm_contact_3, alarm_contact_2,
                     alarm_contact_1, track_circuit_in, wheel_sensor_b,
                     wheel_sensor_a};

    // two-stage synchroniser on every pin
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= `TPAS_IN_RST;
            sync2_reg <= `TPAS_IN_RST;
        end
        else
        begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    // level must hold DEB_CYC cycles before it is accepted
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            deb_reg      <= `TPAS_IN_RST;
            deb_prev_reg <= `TPAS_IN_RST;
            for (int i = 0; i < 7; i++)
            begin
                deb_cnt_reg[i] <= 16'h0000;
            end
        end
        else
        begin
            deb_prev_reg <= deb_reg;
            for (int i = 0; i < 7; i++)
            begin
                if (sync2_reg[i] == deb_reg[i])
                begin
                    deb_cnt_reg[i] <= 16'h0000;
                end
                else if (deb_cnt_reg[i] >= 16'(DEB_CYC - 1))
                begin
                    deb_reg[i]     <= sync2_reg[i];
                    deb_cnt_reg[i] <= 16'h0000;
                end
                else
                begin
                    deb_cnt_reg[i] <= deb_cnt_reg[i] + 16'h0001;
                end
            end
        end
    end

    // input decode
    assign mode        = ctrl_reg[`TPAS_CTRL_MODE_LSB +: 2];
    assign sens_en     = ctrl_reg[`TPAS_CTRL_SENS_LSB +: 2];
    assign is_xducer   = mode == tpas_pkg::TM_XDUCER;
    assign is_appr     = mode == tpas_pkg::TM_APPROACH;
    assign is_cont     = mode == tpas_pkg::TM_CONT;
    assign wheel_rise  = deb_reg[1:0] & ~deb_prev_reg[1:0];
    assign start_pulse = |(wheel_rise & sens_en);
    assign count_pulse = sens_en[0] ? wheel_rise[0] : wheel_rise[1];
    assign track_open  = ~deb_reg[2];
    assign alarm_act   = ~deb_reg[6:3];
    assign alarm_rise  = alarm_act & deb_prev_reg[6:3];
    assign gap_over    = gap_reg >= GAP_CYC;

    // per-input type gate while the track is scanning
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            alarm_hit[i] = alarm_rise[i] && state_reg != tpas_pkg::ST_IDLE
                           && type_ok(types_reg[4*i +: 4], is_cont);
        end
    end

    // lowest numbered input wins when two open together
    always_comb
    begin
        hit_idx = 2'h0;
        for (int i = 3; i >= 0; i--)
        begin
            if (alarm_hit[i])
            begin
                hit_idx = 2'(i);
            end
        end
    end
    assign any_hit = |alarm_hit;

    // presence state machine
    always_comb
    begin
        state_next  = state_reg;
        start_train = 1'b0;
        end_train   = 1'b0;
        unique case (state_reg)
            tpas_pkg::ST_IDLE:
            begin
                if (is_cont)
                begin
                    state_next = tpas_pkg::ST_CONT;
                end
                else if ((is_xducer && start_pulse) || (is_appr && track_open))
                begin
                    state_next  = tpas_pkg::ST_PRESENT;
                    start_train = 1'b1;
                end
            end
            tpas_pkg::ST_PRESENT:
            begin
                if ((is_xducer && gap_over) || (is_appr && !track_open)
                    || !(is_xducer || is_appr))
                begin
                    state_next = tpas_pkg::ST_IDLE;
                    end_train  = 1'b1;
                end
            end
            tpas_pkg::ST_CONT:
            begin
                if (!is_cont)
                begin
                    state_next = tpas_pkg::ST_IDLE;
                end
            end
            default:
            begin
                state_next = tpas_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= tpas_pkg::ST_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // gap timer restarts on every wheel pulse from an enabled sensor
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            gap_reg <= 32'h0000_0000;
        end
        else if (start_train || state_reg != tpas_pkg::ST_PRESENT
                 || start_pulse)
        begin
            gap_reg <= 32'h0000_0000;
        end
        else if (!gap_over && gap_reg < PULSE_MAX_CYC)
        begin
            gap_reg <= gap_reg + 32'h0000_0001;
        end
    end

    // axle count, saturating
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            axle_reg <= 12'h000;
        end
        else if (start_train)
        begin
            axle_reg <= {11'h000, count_pulse};
        end
        else if (state_reg == tpas_pkg::ST_PRESENT && count_pulse
                 && axle_reg != 12'hfff)
        begin
            axle_reg <= axle_reg + 12'h001;
        end
    end

    // passage class decided at train end
    always_comb
    begin
        if (!is_xducer)
        begin
            class_next = tpas_pkg::TC_VALID;
        end
        else if (axle_reg >= `TPAS_VALID_AXLES)
        begin
            class_next = tpas_pkg::TC_VALID;
        end
        else if (axle_reg >= `TPAS_TEST_AXLES)
        begin
            class_next = tpas_pkg::TC_TEST;
        end
        else
        begin
            class_next = tpas_pkg::TC_DROP;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            class_reg <= tpas_pkg::TC_NONE;
        end
        else if (end_train)
        begin
            class_reg <= class_next;
        end
    end

    // alarm records during passage
    assign rec_write = any_hit && state_reg == tpas_pkg::ST_PRESENT
                       && rec_cnt_reg < `TPAS_REC_DEPTH;
    assign mem_bus.wr_en   = rec_write;
    assign mem_bus.wr_addr = rec_cnt_reg[3:0];
    assign mem_bus.wr_data = {2'h0, hit_idx, axle_reg};
    assign mem_bus.rd_addr = avs_address[5:2];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rec_cnt_reg <= 5'h00;
        end
        else if (start_train)
        begin
            rec_cnt_reg <= 5'h00;
        end
        else if (rec_write)
        begin
            rec_cnt_reg <= rec_cnt_reg + 5'h01;
        end
    end

    // event flags, set beats clear
    always_comb
    begin
        ev_set = 4'h0;
        ev_set[`TPAS_EV_ARRIVE] = start_train;
        ev_set[`TPAS_EV_DEPART] = end_train;
        ev_set[`TPAS_EV_ALARM]  = any_hit;
        ev_set[`TPAS_EV_RECORD] = end_train
                                  && class_next != tpas_pkg::TC_DROP;
        ev_clr = wr_events && avs_byteenable[0] ? avs_writedata[3:0] : 4'h0;
        events_next = (events_reg & ~ev_clr) | ev_set;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            events_reg <= 4'h0;
        end
        else
        begin
            events_reg <= events_next;
        end
    end

    // register writes
    assign wr_ctrl   = avs_write && avs_address == `TPAS_OFF_CTRL;
    assign wr_types  = avs_write && avs_address == `TPAS_OFF_TYPES;
    assign wr_events = avs_write && avs_address == `TPAS_OFF_EVENTS;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg <= `TPAS_CTRL_RST;
        end
        else if (wr_ctrl && avs_byteenable[0])
        begin
            ctrl_reg <= avs_writedata[3:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            types_reg <= `TPAS_TYPES_RST;
        end
        else if (wr_types)
        begin
            types_reg <= lane_merge(types_reg, avs_writedata[15:0],
                                    avs_byteenable[1:0]);
        end
    end

    // read decode
    always_comb
    begin
        rd_word = 32'h0000_0000;
        unique case (avs_address)
            `TPAS_OFF_CTRL:   rd_word[3:0]  = ctrl_reg;
            `TPAS_OFF_TYPES:  rd_word[15:0] = types_reg;
            `TPAS_OFF_STATUS: rd_word[10:0] = {deb_reg[1:0], track_open,
                                               class_reg, alarm_act,
                                               scan_active, train_present};
            `TPAS_OFF_EVENTS: rd_word[3:0]  = events_reg;
            `TPAS_OFF_AXLES:  rd_word[20:0] = {rec_cnt_reg, 4'h0, axle_reg};
            default:          rd_word = 32'h0000_0000;
        endcase
    end

    // reads take two cycles: data registered, then waitrequest drops
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_done_reg <= 1'b0;
            rec_sel_reg <= 1'b0;
            rdata_reg   <= 32'h0000_0000;
        end
        else
        begin
            rd_done_reg <= avs_read && !rd_done_reg;
            rec_sel_reg <= avs_address[7:6] == `TPAS_OFF_REC;
            rdata_reg   <= rd_word;
        end
    end

    assign avs_waitrequest = avs_read && !rd_done_reg;
    assign avs_readdata    = rec_sel_reg ? {16'h0000, mem_bus.rd_data}
                                         : rdata_reg;
    assign train_present   = state_reg == tpas_pkg::ST_PRESENT;
    assign scan_active     = state_reg != tpas_pkg::ST_IDLE;
    assign event_pending   = |events_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sensor_start_a: assert property (state_reg == tpas_pkg::ST_IDLE && is_xducer && start_pulse |=> train_present && events_reg[`TPAS_EV_ARRIVE]) else $error("wheel pulse did not start train");
    gap_end_a: assert property (train_present && is_xducer && gap_over |=> !train_present && events_reg[`TPAS_EV_DEPART]) else $error("gap did not end train");
    gap_hold_a: assert property (train_present && is_xducer && gap_reg < GAP_CYC |=> train_present) else $error("train ended early");
    class_valid_a: assert property (end_train && is_xducer && axle_reg >= `TPAS_VALID_AXLES |=> class_reg == tpas_pkg::TC_VALID) else $error("valid train misclassed");
    class_test_a: assert property (end_train && is_xducer && (axle_reg == 12'h002 || axle_reg == 12'h003) |=> class_reg == tpas_pkg::TC_TEST) else $error("test train misclassed");
    class_drop_a: assert property (end_train && is_xducer && axle_reg == 12'h001 && !events_reg[`TPAS_EV_RECORD] && !(wr_events && avs_writedata[`TPAS_EV_RECORD]) |=> class_reg == tpas_pkg::TC_DROP && !events_reg[`TPAS_EV_RECORD]) else $error("single axle logged");
    appr_start_a: assert property (state_reg == tpas_pkg::ST_IDLE && is_appr && track_open |=> train_present) else $error("open circuit did not start");
    appr_hold_a: assert property (train_present && is_appr && track_open |=> train_present) else $error("approach ended while open");
    appr_end_a: assert property (train_present && is_appr && !track_open |=> !scan_active) else $error("closed circuit did not end");
    cont_active_a: assert property (is_cont && $past(is_cont) && $past(is_cont, 2) |-> scan_active) else $error("continuous mode not scanning");
    alarm_report_a: assert property (any_hit |=> events_reg[`TPAS_EV_ALARM]) else $error("alarm not reported");
    type_gate_a: assert property (alarm_hit[0] |-> types_reg[3:0] != 4'h0 && (is_cont || types_reg[3:0] <= 4'h4)) else $error("bad alarm type accepted");
endmodule
`default_nettype wire

//--- tb/tpas_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module tpas_host_model (
    input  wire logic        clk,
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    // bus idle from time zero
    initial
    begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'h0;
    end

    // one transfer, held until waitrequest is sampled low at a rising edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= 4'hf;
        avs_read       <= !w;
        avs_write      <= w;
        // only the bench timeout ends a wait that never completes
        do
        begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        // data taken and request dropped at the completing edge
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb/track_presence_alarm_scanner_tb.sv
`timescale 1ns/1ns
`default_nettype none
module track_presence_alarm_scanner_tb;
    localparam int GAP = 200;
    logic        clk, rst, avs_read, avs_write, avs_waitrequest;
    logic        wheel_sensor_a, wheel_sensor_b, track_circuit_in;
    logic        alarm_contact_1, alarm_contact_2;
    logic        alarm_contact_3, alarm_contact_4;
    logic        train_present, scan_active, event_pending;
    logic [7:0]  avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    int          fails, compares, cycles;

    tpas_scanner #(.GAP_CYC(GAP), .DEB_CYC(3)) u_tpas_scanner (
        .clk(clk), .rst(rst),
        .wheel_sensor_a(wheel_sensor_a), .wheel_sensor_b(wheel_sensor_b),
        .track_circuit_in(track_circuit_in),
        .alarm_contact_1(alarm_contact_1), .alarm_contact_2(alarm_contact_2),
        .alarm_contact_3(alarm_contact_3), .alarm_contact_4(alarm_contact_4),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .train_present(train_present),
        .scan_active(scan_active), .event_pending(event_pending));

    tpas_host_model u_tpas_host_model (
        .clk(clk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fails++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %h vs %h", $time, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        u_tpas_host_model.xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_tpas_host_model.xfer(1'b1, a, d, q);
    endtask

    // one wheel passing over sensor a or b
    task automatic pulse(input logic b);
        if (b) wheel_sensor_b <= 1'b1; else wheel_sensor_a <= 1'b1;
        repeat (10) @(posedge clk);
        wheel_sensor_a <= 1'b0;
        wheel_sensor_b <= 1'b0;
        repeat (140) @(posedge clk);
    endtask

    task automatic reset_vals();
        logic [31:0] q;
        check({29'h0, train_present, scan_active, event_pending}, 32'h0);
        rd(8'h00, q);
        check(q, 32'hc);
        rd(8'h04, q);
        check(q, 32'h0);
        rd(8'h24, q);
        check(q, 32'h0);
    endtask

    // n axles spaced under the gap, then silence past it
    task automatic run_train(input int n, input logic [1:0] cls,
                             input logic b);
        logic [31:0] q;
        wr(8'h00, b ? 32'h8 : 32'h4);
        for (int i = 0; i < n; i++)
            pulse(b);
        check({30'h0, train_present, scan_active}, 32'h3);
        rd(8'h0c, q);
        check({31'h0, q[0]}, 32'h1);
        check({31'h0, event_pending}, 32'h1);
        repeat (GAP + 60) @(posedge clk);
        check({31'h0, train_present}, 32'h0);
        rd(8'h08, q);
        check({30'h0, q[7:6]}, {30'h0, cls});
        rd(8'h0c, q);
        check({28'h0, q[3:0]}, {28'h0, cls != 2'h1, 3'b011});
        rd(8'h10, q);
        check({20'h0, q[11:0]}, 32'(n));
        wr(8'h0c, 32'hf);
    endtask

    // drag alarm accepted, fire refused outside continuous mode
    task automatic alarm_train();
        logic [31:0] q;
        wr(8'h04, 32'h91);
        pulse(1'b0);
        alarm_contact_1 <= 1'b0;
        alarm_contact_2 <= 1'b0;
        repeat (10) @(posedge clk);
        rd(8'h0c, q);
        check({28'h0, q[3:0]}, 32'h5);
        alarm_contact_1 <= 1'b1;
        alarm_contact_2 <= 1'b1;
        repeat (3) pulse(1'b0);
        repeat (GAP + 60) @(posedge clk);
        rd(8'h10, q);
        check({27'h0, q[20:16]}, 32'h1);
        rd(8'h40, q);
        check({18'h0, q[13:0]}, 32'h1);
        wr(8'h0c, 32'hf);
    endtask

    task automatic approach();
        logic [31:0] q;
        wr(8'h00, 32'h1);
        track_circuit_in <= 1'b0;
        repeat (10) @(posedge clk);
        check({30'h0, train_present, scan_active}, 32'h3);
        repeat (GAP + 100) @(posedge clk);
        check({31'h0, train_present}, 32'h1);
        track_circuit_in <= 1'b1;
        repeat (10) @(posedge clk);
        check({30'h0, train_present, scan_active}, 32'h0);
        rd(8'h0c, q);
        check({30'h0, q[1:0]}, 32'h3);
        wr(8'h0c, 32'hf);
    endtask

    task automatic continuous();
        logic [31:0] q;
        wr(8'h04, 32'ha);
        wr(8'h00, 32'h2);
        repeat (3) @(posedge clk);
        check({30'h0, train_present, scan_active}, 32'h1);
        alarm_contact_2 <= 1'b0;
        repeat (10) @(posedge clk);
        check({31'h0, event_pending}, 32'h0);
        alarm_contact_1 <= 1'b0;
        repeat (10) @(posedge clk);
        rd(8'h0c, q);
        check({29'h0, q[2:0]}, 32'h4);
        // mode 3 selects no activation: scanning must stop
        wr(8'h00, 32'h3);
        repeat (2) @(posedge clk);
        check({30'h0, train_present, scan_active}, 32'h0);
    endtask

    // reset, then scenarios in turn
    initial
    begin
        rst = 1'b1;
        wheel_sensor_a = 1'b0;
        wheel_sensor_b = 1'b0;
        track_circuit_in = 1'b1;
        alarm_contact_1 = 1'b1;
        alarm_contact_2 = 1'b1;
        alarm_contact_3 = 1'b1;
        alarm_contact_4 = 1'b1;
        fails = 0;
        compares = 0;
        cycles = 0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        reset_vals();
        run_train(1, 2'h1, 1'b0);
        run_train(2, 2'h2, 1'b0);
        run_train(3, 2'h2, 1'b0);
        run_train(4, 2'h3, 1'b0);
        alarm_train();
        run_train(5, 2'h3, 1'b1);
        approach();
        continuous();
        wrap_up();
    end
endmodule
`default_nettype wire
